//--- rtl/srwc_pkg.sv
package srwc_pkg;
    // Register indices on the plain register port.
    localparam logic [3:0] SRWC_OFS_SLEEP   = 4'h0;
    localparam logic [3:0] SRWC_OFS_PWRRED  = 4'h1;
    localparam logic [3:0] SRWC_OFS_RSTSTAT = 4'h2;
    localparam logic [3:0] SRWC_OFS_SWRST   = 4'h3;
    localparam logic [3:0] SRWC_OFS_PROTECT = 4'h4;
    localparam logic [3:0] SRWC_OFS_WDCTRL  = 4'h5;
    localparam logic [3:0] SRWC_OFS_WDWIN   = 4'h6;
    localparam logic [3:0] SRWC_OFS_BOOT    = 4'h7;
    localparam logic [3:0] SRWC_OFS_STATE   = 4'h8;
    // Key that opens the timed protection window, and its length in cycles.
    localparam logic [7:0] SRWC_PROT_KEY    = 8'hD8;
    localparam logic [2:0] SRWC_PROT_CYC    = 3'h4;
    // Field positions.
    localparam int SRWC_SLP_EN_BIT  = 0;
    localparam int SRWC_WD_EN_BIT   = 0;
    localparam int SRWC_WD_LOCK_BIT = 5;
    localparam int SRWC_WD_WIN_BIT  = 0;
    // Reset cause bits in the status register.
    localparam int SRWC_RC_POR  = 0;
    localparam int SRWC_RC_EXT  = 1;
    localparam int SRWC_RC_BRN  = 2;
    localparam int SRWC_RC_WD   = 3;
    localparam int SRWC_RC_SCAN = 4;
    localparam int SRWC_RC_DBG  = 5;
    localparam int SRWC_RC_SW   = 6;
    // Watchdog: shortest period in ms, longest selector (eleven periods, 8 ms to 8 s).
    localparam logic [13:0] SRWC_WD_MIN_MS  = 14'h0008;
    localparam logic [3:0]  SRWC_WD_SEL_MAX = 4'hA;
    // Reset vector: address 0, or the boot section start when relocated.
    localparam logic [15:0] SRWC_VEC_APP  = 16'h0000;
    localparam logic [15:0] SRWC_VEC_BOOT = 16'h8000;
    // Sleep mode codes.
    typedef enum logic [2:0] {
        SRWC_M_IDLE  = 3'b000,
        SRWC_M_PDOWN = 3'b010,
        SRWC_M_PSAVE = 3'b011,
        SRWC_M_STBY  = 3'b110,
        SRWC_M_ESTBY = 3'b111
    } srwc_mode_t;
    typedef enum logic [0:0] {
        SRWC_ACTIVE = 1'b0,
        SRWC_ASLEEP = 1'b1
    } srwc_phase_t;
    // Register port request.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } srwc_req_t;
    typedef struct packed {
        srwc_phase_t phase;
        logic [2:0]  mode;
        logic        slp_en;
        logic [7:0]  pwr_red;
        logic [6:0]  cause;
        logic [2:0]  prot;
        logic        wd_en;
        logic [3:0]  wd_per;
        logic        wd_win;
        logic [3:0]  wd_min;
        logic        wd_lock;
        logic [13:0] wd_cnt;
        logic        wd_rst;
        logic        sw_rst;
        logic        boot_rel;
        logic        bkp;
        logic [7:0]  rdata;
        logic [6:0]  sync1;
        logic [6:0]  sync2;
        logic        tick_d;
    } srwc_state_t;
    localparam srwc_state_t SRWC_RST_STATE = '0;
endpackage

//--- rtl/srwc_top.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Five sleep modes, wake on enabled source.
// - Idle stops CPU and NVM only.
// - Power-down stops oscillators, RTC; few wakeups.
// - Power-save keeps enabled RTC and its wakeup.
// - Standby keeps oscillators, stops RTC clock.
// - Extended standby keeps oscillators and RTC.
// - Per-peripheral clock stop freezes its state.
// - Reset restores registers, not SRAM.
// - Reset vector zero or boot start.
// - Asynchronous reset, pins float at once.
// - Reset cause readable after reset.
// - Reset held while reset pin low.
// - Watchdog expiry resets when enabled.
// - Brownout resets only when detector enabled.
// - Scan-chain bit and debug port reset.
// - Software reset needs timed protected write.
// - Eleven watchdog periods, 8 ms-8 s.
// - Refresh restarts count; timeout resets.
// - Window mode: early refresh resets too.
// - Watchdog writes protected; lock blocks changes.
// - Always-on fuse keeps watchdog running.
// - Backup domain on battery after brownout.
module srwc_top
    import srwc_pkg::*;
(
    // Clock and logic reset.
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Register port.
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Reset sources, asynchronous to MCLK.
    input  wire logic        POWER_ON_RST,
    input  wire logic        EXT_RESET_N,
    input  wire logic        BROWNOUT_DET,
    input  wire logic        BROWNOUT_EN,
    input  wire logic        SCAN_RST_BIT,
    input  wire logic        PROG_DEBUG_RST,
    input  wire logic        WD_ALWAYS_ON_FUSE,
    input  wire logic        ULTRA_LP_TICK,
    // CPU side events, on MCLK.
    input  wire logic        SLEEP_INSTR,
    input  wire logic        WD_REFRESH_INSTR,
    input  wire logic        IRQ_ENABLED_ANY,
    input  wire logic        IRQ_TWI_MATCH,
    input  wire logic        IRQ_PORT_ASYNC,
    input  wire logic        IRQ_RTC,
    input  wire logic        RTC_ENABLED,
    // Reset and power outputs.
    output logic             RESET_OUT,
    output logic             PORT_HIZ,
    output logic      [15:0] RESET_VECTOR,
    output logic             BACKUP_ON_BAT,
    // Clock gates.
    output logic             CPU_CLK_EN,
    output logic             NVM_CLK_EN,
    output logic             SYS_OSC_EN,
    output logic             RTC_CLK_EN,
    output logic      [7:0]  PER_CLK_EN
);
    srwc_state_t q;
    srwc_state_t d;
    srwc_req_t   req;
    logic        fuse;
    logic        wd_on;
    logic        tick;
    logic        sys_rst;
    logic        wake;
    logic        prot_open;
    logic [13:0] per_ms;
    logic [13:0] min_ms;
    logic [14:0] lim;
    logic        per_on;
    logic [6:0]  src;

    // Period selector to milliseconds; selectors past the last one clamp to 8 s.
    function automatic logic [13:0] wd_ms(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > SRWC_WD_SEL_MAX) ? SRWC_WD_SEL_MAX : sel;
        return SRWC_WD_MIN_MS << s;
    endfunction

    assign req   = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign fuse  = q.sync2[5];
    assign tick  = q.sync2[6] & ~q.tick_d;
    assign wd_on = q.wd_en | fuse;
    assign per_ms = wd_ms(q.wd_per);
    assign min_ms = wd_ms(q.wd_min);
    assign prot_open = (q.prot != 3'h0);
    // Synchronised sources: power-on, pin, brownout, scan, debug.
    assign src = {2'b00, q.sync2[4:0]};
    // The window limit is summed one bit wider: two 8 s periods overflow the count.
    assign lim = q.wd_win ? {1'b0, min_ms} + {1'b0, per_ms}
                          : {1'b0, per_ms};
    assign sys_rst = (|q.sync2[4:0]) | q.wd_rst | q.sw_rst;

    // Reset does not wait for MCLK: pin sources reach the output through gates only.
    always_comb begin
        RESET_OUT = POWER_ON_RST | ~EXT_RESET_N | (BROWNOUT_DET & BROWNOUT_EN)
                  | SCAN_RST_BIT | PROG_DEBUG_RST | q.wd_rst | q.sw_rst;
        PORT_HIZ  = RESET_OUT;
    end

    // Wake sources allowed by the current mode.
    always_comb begin
        wake = IRQ_TWI_MATCH | IRQ_PORT_ASYNC;
        case (q.mode)
            SRWC_M_IDLE:  wake = IRQ_ENABLED_ANY;
            SRWC_M_PSAVE,
            SRWC_M_ESTBY: wake = IRQ_TWI_MATCH | IRQ_PORT_ASYNC
                               | (IRQ_RTC & RTC_ENABLED);
            default:      wake = IRQ_TWI_MATCH | IRQ_PORT_ASYNC;
        endcase
    end

    // Clock gates per mode; a gated peripheral simply holds its state.
    always_comb begin
        CPU_CLK_EN = (q.phase == SRWC_ACTIVE);
        NVM_CLK_EN = (q.phase == SRWC_ACTIVE);
        SYS_OSC_EN = 1'b1;
        RTC_CLK_EN = RTC_ENABLED;
        per_on     = 1'b1;
        if (q.phase == SRWC_ASLEEP) begin
            case (q.mode)
                SRWC_M_IDLE: begin
                    per_on = 1'b1;
                end
                SRWC_M_PDOWN: begin
                    SYS_OSC_EN = 1'b0;
                    RTC_CLK_EN = 1'b0;
                    per_on     = 1'b0;
                end
                SRWC_M_PSAVE: begin
                    SYS_OSC_EN = 1'b0;
                    per_on     = 1'b0;
                end
                SRWC_M_STBY: begin
                    RTC_CLK_EN = 1'b0;
                    per_on     = 1'b0;
                end
                default: begin
                    per_on = 1'b0;
                end
            endcase
        end
        PER_CLK_EN = per_on ? ~q.pwr_red : 8'h00;
    end

    assign RESET_VECTOR  = q.boot_rel ? SRWC_VEC_BOOT : SRWC_VEC_APP;
    assign BACKUP_ON_BAT = q.bkp;
    assign RDATA         = q.rdata;

    always_comb begin
        d = q;
        d.sync1  = {ULTRA_LP_TICK, WD_ALWAYS_ON_FUSE, PROG_DEBUG_RST, SCAN_RST_BIT,
                    BROWNOUT_DET & BROWNOUT_EN, ~EXT_RESET_N, POWER_ON_RST};
        d.sync2  = q.sync1;
        d.tick_d = q.sync2[6];
        d.wd_rst = 1'b0;
        d.sw_rst = 1'b0;
        d.rdata  = 8'h00;
        d.prot   = prot_open ? q.prot - 3'h1 : 3'h0;
        // Backup domain leaves the battery only once both supplies are good.
        if (q.sync2[2]) begin
            d.bkp = 1'b1;
        end else if (!q.sync2[0]) begin
            d.bkp = 1'b0;
        end
        // Sleep entry and wake.
        case (q.phase)
            SRWC_ACTIVE: begin
                if (SLEEP_INSTR && q.slp_en && (q.mode == SRWC_M_IDLE
                        || q.mode == SRWC_M_PDOWN || q.mode == SRWC_M_PSAVE
                        || q.mode == SRWC_M_STBY || q.mode == SRWC_M_ESTBY)) begin
                    d.phase = SRWC_ASLEEP;
                end
            end
            SRWC_ASLEEP: begin
                if (wake) begin
                    d.phase = SRWC_ACTIVE;
                end
            end
            default: begin
                d.phase = SRWC_ACTIVE;
            end
        endcase
        // Watchdog counts in milliseconds from the low-power oscillator tick.
        if (wd_on) begin
            if (WD_REFRESH_INSTR) begin
                d.wd_cnt = 14'h0000;
                if (q.wd_win && q.wd_cnt < min_ms) begin
                    d.wd_rst = 1'b1;
                end
            end else if (tick) begin
                if ({1'b0, q.wd_cnt} + 15'h0001 >= lim) begin
                    d.wd_rst = 1'b1;
                    d.wd_cnt = 14'h0000;
                end else begin
                    d.wd_cnt = q.wd_cnt + 14'h0001;
                end
            end
        end else begin
            d.wd_cnt = 14'h0000;
        end
        // Register writes.
        if (req.wr) begin
            case (req.addr)
                SRWC_OFS_SLEEP: begin
                    d.slp_en = req.wdata[SRWC_SLP_EN_BIT];
                    d.mode   = req.wdata[3:1];
                end
                SRWC_OFS_PWRRED: begin
                    d.pwr_red = req.wdata;
                end
                SRWC_OFS_PROTECT: begin
                    if (req.wdata == SRWC_PROT_KEY) begin
                        d.prot = SRWC_PROT_CYC;
                    end
                end
                SRWC_OFS_SWRST: begin
                    d.sw_rst = prot_open & req.wdata[0];
                end
                SRWC_OFS_WDCTRL: begin
                    if (prot_open && !q.wd_lock) begin
                        d.wd_en   = req.wdata[SRWC_WD_EN_BIT] | fuse;
                        d.wd_per  = req.wdata[4:1];
                        d.wd_lock = req.wdata[SRWC_WD_LOCK_BIT];
                        d.wd_cnt  = 14'h0000;
                    end
                end
                SRWC_OFS_WDWIN: begin
                    if (prot_open && !q.wd_lock) begin
                        d.wd_win = req.wdata[SRWC_WD_WIN_BIT];
                        d.wd_min = req.wdata[4:1];
                    end
                end
                SRWC_OFS_BOOT: begin
                    d.boot_rel = req.wdata[0];
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end
        // Reads answer one cycle later; unmapped indices read zero.
        if (req.rd) begin
            case (req.addr)
                SRWC_OFS_SLEEP:   d.rdata = {4'h0, q.mode, q.slp_en};
                SRWC_OFS_PWRRED:  d.rdata = q.pwr_red;
                SRWC_OFS_RSTSTAT: d.rdata = {1'b0, q.cause};
                SRWC_OFS_WDCTRL:  d.rdata = {2'b00, q.wd_lock, q.wd_per, wd_on};
                SRWC_OFS_WDWIN:   d.rdata = {3'h0, q.wd_min, q.wd_win};
                SRWC_OFS_BOOT:    d.rdata = {7'h00, q.boot_rel};
                SRWC_OFS_STATE:   d.rdata = {4'h0, q.bkp, q.prot != 3'h0, fuse, q.phase};
                default:          d.rdata = 8'h00;
            endcase
        end
        // Cause flags clear by writing ones; a new cause in the same cycle wins.
        if (req.wr && req.addr == SRWC_OFS_RSTSTAT) begin
            d.cause = q.cause & ~req.wdata[6:0];
        end
        d.cause = d.cause | {q.sw_rst, src[4:3], q.wd_rst, src[2:0]};
        // System reset puts every control register back; flags and backup survive.
        if (sys_rst) begin
            d.phase    = SRWC_ACTIVE;
            d.mode     = 3'h0;
            d.slp_en   = 1'b0;
            d.pwr_red  = 8'h00;
            d.prot     = 3'h0;
            d.wd_en    = fuse;
            d.wd_per   = 4'h0;
            d.wd_win   = 1'b0;
            d.wd_min   = 4'h0;
            d.wd_lock  = 1'b0;
            d.wd_cnt   = 14'h0000;
            d.boot_rel = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            q <= SRWC_RST_STATE;
        end else begin
            q <= d;
        end
    end

    sleep_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP |-> !CPU_CLK_EN && !NVM_CLK_EN)
        else $error("CPU clock running in sleep");
    idle_wake_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_IDLE && IRQ_ENABLED_ANY && !sys_rst
        |=> q.phase == SRWC_ACTIVE)
        else $error("idle did not wake on interrupt");
    pdown_clocks_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_PDOWN |-> !SYS_OSC_EN && !RTC_CLK_EN
        && PER_CLK_EN == 8'h00)
        else $error("clocks running in power-down");
    pdown_stay_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_PDOWN && !IRQ_TWI_MATCH
        && !IRQ_PORT_ASYNC && !sys_rst |=> q.phase == SRWC_ASLEEP)
        else $error("power-down woke on disallowed source");
    psave_rtc_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_PSAVE |-> RTC_CLK_EN == RTC_ENABLED
        && !SYS_OSC_EN)
        else $error("power-save RTC gate wrong");
    stby_osc_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_STBY |-> SYS_OSC_EN && !RTC_CLK_EN)
        else $error("standby gating wrong");
    estby_osc_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_ESTBY |-> SYS_OSC_EN
        && RTC_CLK_EN == RTC_ENABLED)
        else $error("extended standby gating wrong");
    per_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        WR && ADDR == SRWC_OFS_PWRRED && q.phase == SRWC_ACTIVE && !sys_rst
        |=> q.phase != SRWC_ACTIVE || PER_CLK_EN == ~$past(WDATA))
        else $error("peripheral gate does not follow write");
    pin_reset_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !EXT_RESET_N |-> RESET_OUT && PORT_HIZ)
        else $error("reset pin low without reset");
    sw_guard_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        WR && ADDR == SRWC_OFS_SWRST && q.prot == 3'h0 |=> !q.sw_rst)
        else $error("software reset without protection");
    wd_lock_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.wd_lock && !sys_rst |=> $stable(q.wd_per) && $stable(q.wd_en))
        else $error("locked watchdog changed");
    wd_fuse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        fuse && WR && ADDR == SRWC_OFS_WDCTRL && prot_open && !q.wd_lock |=> q.wd_en)
        else $error("fuse watchdog off");
    bkp_switch_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.sync2[2] |=> BACKUP_ON_BAT)
        else $error("backup not on battery after brownout");

    // Watchdog and software pulses last one cycle, so these checks look at that cycle.
    vector_sel_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        WR && ADDR == SRWC_OFS_BOOT && !sys_rst
        |=> RESET_VECTOR == ($past(WDATA[0]) ? SRWC_VEC_BOOT : SRWC_VEC_APP))
        else $error("reset vector does not follow boot select");
    wd_reset_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.wd_rst |-> RESET_OUT && PORT_HIZ)
        else $error("watchdog expiry without reset");
    cause_wd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.wd_rst |=> q.cause[SRWC_RC_WD])
        else $error("watchdog cause not recorded");
    cause_sw_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.sw_rst |=> q.cause[SRWC_RC_SW])
        else $error("software cause not recorded");
    refresh_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        wd_on && WD_REFRESH_INSTR |=> q.wd_cnt == 14'h0000)
        else $error("refresh did not restart count");
    win_early_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        wd_on && q.wd_win && WD_REFRESH_INSTR && q.wd_cnt < min_ms |=> q.wd_rst)
        else $error("early refresh in window mode without reset");
    sleep_entry_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ACTIVE && !SLEEP_INSTR |=> q.phase == SRWC_ACTIVE)
        else $error("sleep entered without sleep instruction");
    brn_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.sync2[2] |-> $past(BROWNOUT_EN, 2) && $past(BROWNOUT_DET, 2))
        else $error("brownout reset with detector off");
    bkp_return_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        BACKUP_ON_BAT && !q.sync2[2] && !q.sync2[0] |=> !BACKUP_ON_BAT)
        else $error("backup stays on battery after supplies good");
    sleep_idle_c: cover property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_IDLE ##1 q.phase == SRWC_ACTIVE);
    wd_expire_c: cover property (@(posedge MCLK) disable iff (!RST_N) q.wd_rst);
    sw_reset_c: cover property (@(posedge MCLK) disable iff (!RST_N) q.sw_rst);
    pdown_wake_c: cover property (@(posedge MCLK) disable iff (!RST_N)
        q.phase == SRWC_ASLEEP && q.mode == SRWC_M_PDOWN ##1 q.phase == SRWC_ACTIVE);
    win_reset_c: cover property (@(posedge MCLK) disable iff (!RST_N)
        q.wd_win && q.wd_rst);
endmodule

//--- tb/test_sleep_reset_watchdog_control.sv
`timescale 1ns/1ps
module test_sleep_reset_watchdog_control;
    import srwc_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    srwc_req_t   req = '0;
    logic        por = 1'b0, ext_n = 1'b1, brn_det = 1'b0, brn_en = 1'b0;
    logic        scan_rst = 1'b0, dbg_rst = 1'b0, fuse = 1'b0, tick = 1'b0;
    logic        wd_ref = 1'b0, rtc_en = 1'b1;
    logic [4:0]  ev = '0;
    logic [7:0]  rdata, per_en, pwr;
    logic [15:0] vec;
    logic        rst_out, hiz, bat, cpu_en, nvm_en, osc_en, rtc_clk;
    logic        rst_seen = 1'b0;
    int          err_total = 0;
    int          checks_done = 0;
    int          seed = 32'heb731109;
    int          exp_reg [0:15];
    int          cause = 0;
    int          cbit [0:4];
    srwc_mode_t  modes [0:4];
    srwc_mode_t  m;

    srwc_top u_dut (
        .MCLK(mclk), .RST_N(rst_n), .ADDR(req.addr), .WDATA(req.wdata), .WR(req.wr),
        .RD(req.rd), .RDATA(rdata), .POWER_ON_RST(por), .EXT_RESET_N(ext_n),
        .BROWNOUT_DET(brn_det), .BROWNOUT_EN(brn_en), .SCAN_RST_BIT(scan_rst),
        .PROG_DEBUG_RST(dbg_rst), .WD_ALWAYS_ON_FUSE(fuse), .ULTRA_LP_TICK(tick),
        .SLEEP_INSTR(ev[0]), .WD_REFRESH_INSTR(wd_ref), .IRQ_ENABLED_ANY(ev[1]),
        .IRQ_TWI_MATCH(ev[2]), .IRQ_PORT_ASYNC(ev[3]), .IRQ_RTC(ev[4]),
        .RTC_ENABLED(rtc_en), .RESET_OUT(rst_out), .PORT_HIZ(hiz), .RESET_VECTOR(vec),
        .BACKUP_ON_BAT(bat), .CPU_CLK_EN(cpu_en), .NVM_CLK_EN(nvm_en),
        .SYS_OSC_EN(osc_en), .RTC_CLK_EN(rtc_clk), .PER_CLK_EN(per_en)
    );

    always #2 mclk = ~mclk;

    // Pulses from the watchdog or software last one cycle, so they are latched here.
    always @(negedge mclk) begin
        if (rst_out === 1'b1) rst_seen <= 1'b1;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge mclk);
        req.wr    <= 1'b0;
        if (a == SRWC_OFS_PWRRED || a == SRWC_OFS_BOOT) exp_reg[a] = d;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge mclk);
        req.rd   <= 1'b0;
        #1 chk(name, rdata, e);
    endtask

    task automatic prot_wr(input logic [3:0] a, input logic [7:0] d);
        wr(SRWC_OFS_PROTECT, SRWC_PROT_KEY);
        wr(a, d);
    endtask

    // A system reset clears the model's control registers; cause flags survive.
    task automatic note_cause(input int b);
        foreach (exp_reg[i]) exp_reg[i] = 0;
        cause = cause | (1 << b);
        rd_chk("cause", SRWC_OFS_RSTSTAT, cause[7:0]);
        wr(SRWC_OFS_RSTSTAT, 8'hFF);
        cause = 0;
        rd_chk("pwr_red_cleared", SRWC_OFS_PWRRED, exp_reg[SRWC_OFS_PWRRED]);
    endtask

    task automatic pulse(input logic [4:0] p);
        @(posedge mclk);
        ev <= p;
        @(posedge mclk);
        ev <= '0;
        #1;
    endtask

    task automatic lp_tick();
        @(posedge mclk);
        tick <= 1'b1;
        repeat (3) @(posedge mclk);
        tick <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic refresh();
        @(posedge mclk);
        wd_ref <= 1'b1;
        @(posedge mclk);
        wd_ref <= 1'b0;
    endtask

    task automatic set_src(input int i, input logic on);
        case (i)
            0: por <= on;
            1: ext_n <= ~on;
            2: brn_det <= on;
            3: scan_rst <= on;
            default: dbg_rst <= on;
        endcase
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        wrap_up();
    end

    initial begin
        cbit  = '{SRWC_RC_POR, SRWC_RC_EXT, SRWC_RC_BRN, SRWC_RC_SCAN, SRWC_RC_DBG};
        modes = '{SRWC_M_IDLE, SRWC_M_PDOWN, SRWC_M_PSAVE, SRWC_M_STBY, SRWC_M_ESTBY};
        foreach (exp_reg[i]) exp_reg[i] = 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk("reset_out_idle", rst_out, 0);
        chk("vector", vec, SRWC_VEC_APP);
        rd_chk("cause_zero", SRWC_OFS_RSTSTAT, 8'h00);
        rd_chk("unmapped", 4'hF, 8'h00);
        wr(SRWC_OFS_BOOT, 8'h01);
        repeat (2) @(posedge mclk);
        #1 chk("vector_boot", vec, SRWC_VEC_BOOT);
        rd_chk("boot", SRWC_OFS_BOOT, 8'h01);
        // The detector is switched off here, so a low supply must not reset.
        @(posedge mclk);
        brn_det <= 1'b1;
        repeat (5) @(posedge mclk);
        #1 chk("brownout_off", rst_out, 0);
        @(posedge mclk);
        brn_det <= 1'b0;
        brn_en  <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            pwr = $random(seed);
            wr(SRWC_OFS_PWRRED, pwr);
            #1 chk("per_clk", per_en, 8'(~pwr));
            @(posedge mclk);
            set_src(i, 1'b1);
            #1 chk("reset_now", rst_out, 1);
            chk("hiz_now", hiz, 1);
            repeat (6) @(posedge mclk);
            #1 chk("reset_held", rst_out, 1);
            if (i == 2) chk("on_battery", bat, 1);
            @(posedge mclk);
            set_src(i, 1'b0);
            repeat (6) @(posedge mclk);
            #1 chk("reset_gone", rst_out, 0);
            chk("main_power", bat, 0);
            note_cause(cbit[i]);
        end
        rst_seen = 1'b0;
        wr(SRWC_OFS_SWRST, 8'h01);
        repeat (3) @(posedge mclk);
        chk("sw_no_key", rst_seen, 0);
        prot_wr(SRWC_OFS_SWRST, 8'h01);
        repeat (3) @(posedge mclk);
        chk("sw_reset", rst_seen, 1);
        note_cause(SRWC_RC_SW);
        pwr = $random(seed);
        wr(SRWC_OFS_PWRRED, pwr);
        wr(SRWC_OFS_SLEEP, 8'h00);
        pulse(5'b00001);
        chk("sleep_off", cpu_en, 1);
        foreach (modes[i]) begin
            m = modes[i];
            wr(SRWC_OFS_SLEEP, {4'h0, m, 1'b1});
            pulse(5'b00001);
            chk("cpu_sleep", cpu_en, 0);
            chk("nvm_sleep", nvm_en, 0);
            chk("osc_sleep", osc_en, m == SRWC_M_IDLE || m[2]);
            chk("per_sleep", per_en, (m == SRWC_M_IDLE) ? 8'(~pwr) : 8'h00);
            if (m != SRWC_M_IDLE) chk("rtc_sleep", rtc_clk, m[0]);
            if (!m[0] && m != SRWC_M_IDLE) begin
                pulse(5'b10000);
                chk("no_wake", cpu_en, 0);
            end
            // A disabled counter neither runs nor wakes the core.
            if (m[0]) begin
                @(posedge mclk);
                rtc_en <= 1'b0;
                pulse(5'b10000);
                chk("rtc_off", rtc_clk, 0);
                chk("rtc_no_wake", cpu_en, 0);
                @(posedge mclk);
                rtc_en <= 1'b1;
            end
            case (m)
                SRWC_M_IDLE: pulse(5'b00010);
                SRWC_M_PSAVE, SRWC_M_ESTBY: pulse(5'b10000);
                default: pulse(($random(seed) & 1) ? 5'b00100 : 5'b01000);
            endcase
            chk("wake", cpu_en, 1);
            chk("wake_nvm", nvm_en, 1);
        end
        for (int s = 0; s < 2; s++) begin
            prot_wr(SRWC_OFS_WDCTRL, {2'b00, s == 0, s[3:0], 1'b1});
            rd_chk("wd_ctrl", SRWC_OFS_WDCTRL, {2'b00, s == 0, s[3:0], 1'b1});
            if (s == 0) begin
                prot_wr(SRWC_OFS_WDCTRL, 8'h00);
                rd_chk("wd_locked", SRWC_OFS_WDCTRL, 8'h21);
            end
            rst_seen = 1'b0;
            repeat ((8 << s) - 1) lp_tick();
            refresh();
            repeat ((8 << s) - 1) lp_tick();
            chk("wd_early", rst_seen, 0);
            lp_tick();
            repeat (3) @(posedge mclk);
            chk("wd_expire", rst_seen, 1);
            note_cause(SRWC_RC_WD);
        end
        prot_wr(SRWC_OFS_WDWIN, 8'h01);
        prot_wr(SRWC_OFS_WDCTRL, 8'h01);
        rst_seen = 1'b0;
        repeat (9) lp_tick();
        refresh();
        repeat (3) lp_tick();
        chk("win_inside", rst_seen, 0);
        refresh();
        repeat (3) @(posedge mclk);
        chk("win_early", rst_seen, 1);
        note_cause(SRWC_RC_WD);
        @(posedge mclk);
        fuse <= 1'b1;
        repeat (4) @(posedge mclk);
        prot_wr(SRWC_OFS_WDCTRL, 8'h00);
        rd_chk("wd_fuse", SRWC_OFS_WDCTRL, 8'h01);
        rst_seen = 1'b0;
        repeat (8) lp_tick();
        repeat (3) @(posedge mclk);
        chk("fuse_expire", rst_seen, 1);
        note_cause(SRWC_RC_WD);
        wrap_up();
    end
endmodule
